// ### ifh_pkg.sv
`default_nettype none
package ifh_pkg;

  // Register bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [15:0] OFF_FLAG_CLR = 16'h0010;
  localparam logic [15:0] OFF_FLAGS    = 16'h0011;
  localparam logic [15:0] OFF_ENABLES  = 16'h0012;
  localparam logic [15:0] OFF_IN_DATA  = 16'h0014;
  localparam logic [15:0] OFF_OUT_DATA = 16'h0015;
  localparam logic [15:0] OFF_PIN_CTRL = 16'h0016;
  localparam logic [15:0] OFF_CPU_STAT = 16'h0017;

  // Flag and enable bit positions
  localparam int FB_RISE    = 0;
  localparam int FB_FALL    = 1;
  localparam int FB_IN_FULL = 2;
  localparam int FB_OUT_FUL = 3;
  localparam int FB_IN_READ = 4;
  localparam int FB_CNT_OVF = 5;
  localparam int NUM_FLAGS  = 6;

  // Flags that software may clear through the bit-clear path
  localparam logic [5:0] SW_CLR_MASK = 6'h23;
  // Sources that also drive the host interrupt
  localparam logic [5:0] HOST_MASK   = 6'h18;

  // Reset values
  localparam logic [5:0] FLAGS_RST   = 6'h10;
  localparam logic [5:0] ENABLES_RST = 6'h00;
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [7:0] CLR_RD_VAL  = 8'hff;

  // Pin control register fields
  localparam int PC_SEL_BIT  = 5;
  localparam int PC_DATA_BIT = 6;

  // Host status fields and CPU status fields
  localparam int HS_OUT_FULL = 0;
  localparam int HS_IN_FULL  = 1;
  localparam int CS_MASK     = 0;
  localparam int CS_BREAK    = 1;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } ifh_bus_req_t;

  typedef struct packed {
    logic       rs;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ifh_host_req_t;

endpackage
`default_nettype wire

// ### ifh_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module ifh_irq_ctrl
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // Internal register bus
  input  wire ifh_pkg::ifh_bus_req_t bus_req,
  output var  logic [7:0]           bus_rdata_q,
  // Host data port
  input  wire ifh_pkg::ifh_host_req_t host_req,
  output var  logic [7:0]           host_rdata_q,
  // Event sources
  input  wire logic                 port_a_line0,
  input  wire logic                 port_a_line1,
  input  wire logic                 counter_ovf,
  // CPU sequencing hooks
  input  wire logic                 mask_set,
  input  wire logic                 mask_clr,
  input  wire logic                 soft_break_op,
  input  wire logic                 insn_boundary,
  // CPU interrupt outputs
  output var  logic                 cpu_irq_n_q,
  output var  logic                 svc_entry_q,
  output var  logic                 break_flag_q,
  // Port C line 6 pin
  input  wire logic                 port_c_line6_i,
  output var  logic                 port_c_line6_o_q,
  output var  logic                 port_c_line6_oe_q
);
  import ifh_pkg::*;

  // Address match used by the strobe and write decodes below; the read data mux uses a case
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] off);
    hit = (a == off);
  endfunction

  logic [5:0] flags_q;
  logic [5:0] flags_d;
  logic [5:0] enables_q;
  logic [5:0] clr_snap_q;
  logic [7:0] in_data_q;
  logic [7:0] out_data_q;
  logic       in_full_q;
  logic       out_full_q;
  logic       pin_sel_q;
  logic       pin_data_q;
  logic       mask_q;
  logic       pa0_q;
  logic       pa1_q;
  logic [5:0] set_ev;
  logic [5:0] clr_ev;
  logic [5:0] pend;
  logic       take_hw;
  logic       cpu_rd_in;
  logic       cpu_wr_out;
  logic       host_wr_in;
  logic       host_rd_out;
  logic       host_rd_stat;
  logic       host_pend;

  // Decoded strobes
  assign cpu_rd_in    = bus_req.rd && hit(bus_req.addr, OFF_IN_DATA);
  assign cpu_wr_out   = bus_req.wr && hit(bus_req.addr, OFF_OUT_DATA);
  assign host_wr_in   = host_req.wr;
  assign host_rd_out  = host_req.rd && !host_req.rs;
  assign host_rd_stat = host_req.rd && host_req.rs;

  // Previous pin levels for edge detection
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pa0_q <= 1'b0;
      pa1_q <= 1'b1;
    end
    else
    begin
      pa0_q <= port_a_line0;
      pa1_q <= port_a_line1;
    end
  end

  // Flag set and clear events
  always_comb
  begin
    set_ev = '0;
    clr_ev = '0;
    set_ev[FB_RISE]    = port_a_line0 && !pa0_q;
    set_ev[FB_FALL]    = !port_a_line1 && pa1_q;
    set_ev[FB_IN_FULL] = host_wr_in;
    set_ev[FB_OUT_FUL] = cpu_wr_out;
    set_ev[FB_IN_READ] = cpu_rd_in;
    set_ev[FB_CNT_OVF] = counter_ovf;
    clr_ev[FB_IN_FULL] = cpu_rd_in;
    clr_ev[FB_OUT_FUL] = host_rd_out;
    clr_ev[FB_IN_READ] = host_rd_stat;
    // Only bits seen set at the clear read may be cleared; a flag
    // that rises between the two cycles stays pending
    if (bus_req.wr && hit(bus_req.addr, OFF_FLAGS))
    begin
      clr_ev = clr_ev
        | (~bus_req.wdata[5:0] & clr_snap_q & SW_CLR_MASK);
    end
  end

  // New events win over a clear in the same cycle
  assign flags_d = (flags_q & ~clr_ev) | set_ev;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_q <= FLAGS_RST;
    else
      flags_q <= flags_d;
  end

  // Snapshot of flags taken on the read half of a bit clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      clr_snap_q <= '0;
    else if (bus_req.rd && hit(bus_req.addr, OFF_FLAG_CLR))
      clr_snap_q <= flags_q;
  end

  // Enable register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      enables_q <= ENABLES_RST;
    else if (bus_req.wr && hit(bus_req.addr, OFF_ENABLES))
      enables_q <= bus_req.wdata[5:0];
  end

  // Data registers and host-visible full flags
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_data_q  <= DATA_RST;
      out_data_q <= DATA_RST;
    end
    else
    begin
      if (host_wr_in)
        in_data_q <= host_req.wdata;
      if (cpu_wr_out)
        out_data_q <= bus_req.wdata;
    end
  end

  // Set wins over clear for both full flags
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_full_q  <= 1'b0;
      out_full_q <= 1'b0;
    end
    else
    begin
      in_full_q  <= host_wr_in || (in_full_q && !cpu_rd_in);
      out_full_q <= cpu_wr_out
                 || (out_full_q && !host_rd_out);
    end
  end

  // Pin control register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_sel_q  <= 1'b0;
      pin_data_q <= 1'b1;
    end
    else if (bus_req.wr && hit(bus_req.addr, OFF_PIN_CTRL))
    begin
      pin_sel_q  <= bus_req.wdata[PC_SEL_BIT];
      pin_data_q <= bus_req.wdata[PC_DATA_BIT];
    end
  end

  // Pending enabled conditions, from next flag state for no lag
  assign pend      = flags_d & enables_q;
  assign host_pend = |(pend & HOST_MASK);

  // CPU request stays low until every enabled flag is cleared
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cpu_irq_n_q <= 1'b1;
    else
      cpu_irq_n_q <= ~|pend;
  end

  // Port C line 6: open pull-down port bit or driven host interrupt
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port_c_line6_o_q  <= 1'b1;
      port_c_line6_oe_q <= 1'b0;
    end
    else if (pin_sel_q)
    begin
      port_c_line6_o_q  <= ~host_pend;
      port_c_line6_oe_q <= 1'b1;
    end
    else
    begin
      port_c_line6_o_q  <= 1'b0;
      port_c_line6_oe_q <= ~pin_data_q;
    end
  end

  // Interrupt mask; entry also masks further requests
  assign take_hw = !cpu_irq_n_q && !mask_q && insn_boundary;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      mask_q <= 1'b1;
    else if (mask_set || take_hw || soft_break_op)
      mask_q <= 1'b1;
    else if (mask_clr)
      mask_q <= 1'b0;
  end

  // Service entry pulse and break flag
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      svc_entry_q  <= 1'b0;
      break_flag_q <= 1'b0;
    end
    else
    begin
      svc_entry_q <= soft_break_op || take_hw;
      if (soft_break_op)
        break_flag_q <= 1'b1;
      else if (take_hw)
        break_flag_q <= 1'b0;
    end
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      bus_rdata_q <= '0;
    else if (bus_req.rd)
    begin
      case (bus_req.addr)
        OFF_FLAG_CLR: bus_rdata_q <= CLR_RD_VAL;
        OFF_FLAGS:    bus_rdata_q <= {2'b00, flags_q};
        OFF_ENABLES:  bus_rdata_q <= {2'b00, enables_q};
        OFF_IN_DATA:  bus_rdata_q <= in_data_q;
        OFF_OUT_DATA: bus_rdata_q <= out_data_q;
        OFF_PIN_CTRL: bus_rdata_q <= {1'b0, port_c_line6_i,
                                      pin_sel_q, 5'h00};
        OFF_CPU_STAT: bus_rdata_q <= {6'h00, break_flag_q, mask_q};
        default:      bus_rdata_q <= '0;
      endcase
    end
    else
      bus_rdata_q <= '0;
  end

  // Host read data: output register or status flags
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      host_rdata_q <= '0;
    else if (host_rd_out)
      host_rdata_q <= out_data_q;
    else if (host_rd_stat)
      host_rdata_q <= {6'h00, in_full_q, out_full_q};
    else
      host_rdata_q <= '0;
  end

endmodule
`default_nettype wire

// ### ifh_irq_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module ifh_irq_props
(
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   reset_n,
  // Watched ports
  input wire ifh_pkg::ifh_bus_req_t  bus_req,
  input wire logic [7:0]             bus_rdata_q,
  input wire ifh_pkg::ifh_host_req_t host_req,
  input wire logic [7:0]             host_rdata_q,
  input wire logic                   port_a_line0,
  input wire logic                   counter_ovf,
  input wire logic                   soft_break_op,
  input wire logic                   svc_entry_q,
  input wire logic                   break_flag_q
);
  import ifh_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Flag register read, shared by several checks
  wire logic fl_rd = bus_req.rd && bus_req.addr == OFF_FLAGS;
  // Read data must not linger, or stale flags leak to software
  AST_RD_IDLE: assert property (
    !bus_req.rd |=> bus_rdata_q == 8'h00)
    else $error("read data not idle");
  AST_CLR_ONES: assert property (
    bus_req.rd && bus_req.addr == OFF_FLAG_CLR |=> bus_rdata_q == 8'hff)
    else $error("clear address not ones");
  AST_TOP_BITS: assert property (
    fl_rd |=> bus_rdata_q[7:6] == 2'b00)
    else $error("flag top bits set");
  AST_RISE_FLAG: assert property (
    $rose(port_a_line0) ##[1:4] fl_rd |=> bus_rdata_q[FB_RISE])
    else $error("rise flag missing");
  AST_OVF_FLAG: assert property (
    counter_ovf ##[1:4] fl_rd |=> bus_rdata_q[FB_CNT_OVF])
    else $error("overflow flag missing");
  AST_HOST_STAT: assert property (
    host_req.rd && host_req.rs |=> host_rdata_q[7:2] == 6'h00)
    else $error("host status layout");
  // Entry sets the mask, so a held request cannot re-enter
  AST_SVC_MASK: assert property (
    svc_entry_q && !soft_break_op |=> !svc_entry_q)
    else $error("service re-entered");
  AST_BRK_HW: assert property (
    svc_entry_q && !$past(soft_break_op) |-> !break_flag_q)
    else $error("break flag on hardware entry");
  AST_BRK_SW: assert property (
    soft_break_op |=> svc_entry_q && break_flag_q)
    else $error("break entry missing");
endmodule
bind ifh_irq_ctrl ifh_irq_props u_props (.core_clk, .reset_n, .bus_req,
  .bus_rdata_q, .host_req, .host_rdata_q, .port_a_line0, .counter_ovf,
  .soft_break_op, .svc_entry_q, .break_flag_q);
`default_nettype wire

// ### ifh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifh_host_model
(
  // Clock
  input  wire logic                   core_clk,
  // Host data port
  output var  ifh_pkg::ifh_host_req_t host_req,
  input  wire logic [7:0]             host_rdata_q,
  // Interrupt pin with pull-up
  input  wire logic                   port_c_line6_o_q,
  input  wire logic                   port_c_line6_oe_q,
  output wire logic                   port_c_line6_i
);
  import ifh_pkg::*;
  // Released pin floats high through the pull-up
  assign port_c_line6_i = port_c_line6_oe_q ? port_c_line6_o_q : 1'b1;
  initial host_req = '0;
  // One-cycle write; idle bus shows inverted data, never the last value
  task automatic hwr(input logic rs, input logic [7:0] d);
    @(posedge core_clk);
    host_req <= '{rs: rs, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge core_clk);
    host_req <= '{rs: ~rs, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic hrd(input logic rs, output logic [7:0] d);
    @(posedge core_clk);
    host_req <= '{rs: rs, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge core_clk);
    host_req <= '0;
    #1 d = host_rdata_q;
  endtask
endmodule
`default_nettype wire

// ### ifh_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  num_errors++; $display("[ERR] %s exp %h got %h", n, e, g); \
  end end
module tb;
  import ifh_pkg::*;
  // Stimulus and observed ports
  logic          core_clk, reset_n, port_a_line0, port_a_line1;
  logic          counter_ovf, mask_clr, soft_break_op, insn_boundary;
  logic          cpu_irq_n_q, svc_entry_q, break_flag_q, port_c_line6_i;
  logic          port_c_line6_o_q, port_c_line6_oe_q;
  logic [7:0]    bus_rdata_q, host_rdata_q, d;
  ifh_bus_req_t  bus_req;
  ifh_host_req_t host_req;
  int            num_errors, checked, cycles, svc_n;
  // Block under test and host partner
  ifh_irq_ctrl DUT (.core_clk, .reset_n, .bus_req, .bus_rdata_q, .host_req,
    .host_rdata_q, .port_a_line0, .port_a_line1, .counter_ovf,
    .mask_set(1'b0), .mask_clr, .soft_break_op, .insn_boundary,
    .cpu_irq_n_q, .svc_entry_q, .break_flag_q, .port_c_line6_i,
    .port_c_line6_o_q, .port_c_line6_oe_q);
  ifh_host_model HOST (.core_clk, .host_req, .host_rdata_q,
    .port_c_line6_o_q, .port_c_line6_oe_q, .port_c_line6_i);
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Hang guard well above the run length; also counts service entries
  always @(posedge core_clk)
  begin
    cycles++;
    if (svc_entry_q === 1'b1)
      svc_n++;
    if (cycles == 3000)
    begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cw(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  task automatic cr(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1 `CHK($sformatf("reg %h", a), e, bus_rdata_q)
  endtask
  // One-cycle pulse on {break, mask clear, overflow}
  task automatic pulse(input logic [2:0] m);
    @(posedge core_clk);
    {soft_break_op, mask_clr, counter_ovf} <= m;
    @(posedge core_clk);
    {soft_break_op, mask_clr, counter_ovf} <= 3'b000;
  endtask
  // Outputs as {cpu request, pin enable, pin level}, one edge of slack
  task automatic outs(input logic [2:0] e);
    @(posedge core_clk);
    #1 `CHK("outs", e, {cpu_irq_n_q, port_c_line6_oe_q, port_c_line6_o_q})
  endtask
  initial
  begin
    bus_req = '0;
    {port_a_line0, port_a_line1, insn_boundary, reset_n} = 4'b0100;
    {soft_break_op, mask_clr, counter_ovf} = 3'b000;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    outs(3'b100);
    cr(OFF_FLAGS, 8'h10);
    cr(OFF_ENABLES, 8'h00);
    cr(16'h0020, 8'h00);
    cw(OFF_ENABLES, 8'h3f);
    cr(OFF_ENABLES, 8'h3f);
    cw(OFF_ENABLES, 8'h23);
    cr(OFF_ENABLES, 8'h23);
    // Three sources pending; request holds until the last is cleared
    port_a_line0 <= 1'b1;
    port_a_line1 <= 1'b0;
    pulse(3'b001);
    cr(OFF_FLAGS, 8'h33);
    outs(3'b000);
    foreach (d[i])
      if (i == 0 || i == 1 || i == 5)
      begin
        cr(OFF_FLAG_CLR, 8'hff);
        cw(OFF_FLAGS, ~(8'h01 << i));
        outs({i == 0, 2'b00});
      end
    // Overflow lands between the clear's read and write
    fork
      cr(OFF_FLAG_CLR, 8'hff);
      pulse(3'b001);
    join
    cw(OFF_FLAGS, 8'hdf);
    cr(OFF_FLAGS, 8'h30);
    cr(OFF_FLAG_CLR, 8'hff);
    cw(OFF_FLAGS, 8'hdf);
    cr(OFF_FLAGS, 8'h10);
    // Output register toward the host
    cw(OFF_PIN_CTRL, 8'h20);
    cw(OFF_ENABLES, 8'h08);
    cw(OFF_OUT_DATA, 8'ha5);
    cr(OFF_FLAGS, 8'h18);
    outs(3'b010);
    HOST.hrd(1'b1, d);
    `CHK("host stat", 8'h01, d)
    HOST.hrd(1'b0, d);
    `CHK("host data", 8'ha5, d)
    outs(3'b111);
    cr(OFF_PIN_CTRL, 8'h60);
    cr(OFF_FLAGS, 8'h00);
    // Input register from the host
    cw(OFF_ENABLES, 8'h14);
    HOST.hwr(1'b0, 8'h3c);
    cr(OFF_FLAGS, 8'h04);
    outs(3'b011);
    HOST.hrd(1'b1, d);
    `CHK("host stat", 8'h02, d)
    cr(OFF_IN_DATA, 8'h3c);
    cr(OFF_FLAGS, 8'h10);
    outs(3'b010);
    HOST.hrd(1'b1, d);
    `CHK("host stat", 8'h00, d)
    outs(3'b111);
    cr(OFF_FLAGS, 8'h00);
    cw(OFF_PIN_CTRL, 8'h00);
    outs(3'b110);
    // Service entry: masked after reset, then hardware, then break
    cw(OFF_ENABLES, 8'h20);
    insn_boundary <= 1'b1;
    pulse(3'b001);
    outs(3'b010);
    `CHK("svc", 0, svc_n)
    pulse(3'b010);
    repeat (3) @(posedge core_clk);
    #1 `CHK("svc", 1, svc_n)
    `CHK("brk", 1'b0, break_flag_q)
    pulse(3'b100);
    repeat (3) @(posedge core_clk);
    #1 `CHK("svc", 2, svc_n)
    `CHK("brk", 1'b1, break_flag_q)
    cr(OFF_CPU_STAT, 8'h03);
    stop_test();
  end
endmodule
`default_nettype wire
